/* File: rtl/lts_ahb_slave.sv */
// AHB-Lite slave front end: captures address phase, issues register strobes
`timescale 1ns/1ps
`default_nettype none
module lts_ahb_slave (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Bus request
	input wire lts_pkg::lts_ahb_req_t req,
	// Register side
	output logic wrEn,
	output logic [7:0] wrAddr,
	output logic [31:0] wrData,
	output logic rdEn,
	output logic [7:0] rdAddr
);
	import lts_pkg::*;

	logic pendWrite;
	logic [7:0] pendAddr;
	logic addrPhase;

	// Zero wait states: every accepted address phase completes next cycle
	assign addrPhase = req.hsel && req.htrans[1] && req.hready;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pendWrite <= 1'b0;
			pendAddr <= 8'h00;
		end else begin
			pendWrite <= addrPhase && req.hwrite;
			if (addrPhase) begin
				pendAddr <= req.haddr;
			end
		end
	end

	assign wrEn = pendWrite;
	assign wrAddr = pendAddr;
	assign wrData = req.hwdata;
	// Read is decoded in the address phase so hrdata is a flop in the data phase
	assign rdEn = addrPhase && !req.hwrite;
	assign rdAddr = req.haddr;
endmodule
`default_nettype wire

/* File: rtl/lts_params.svh */
// Constants for the link training status report block
`ifndef LTS_PARAMS_SVH
`define LTS_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LTS_OFS_STATUS 8'h00
`define LTS_OFS_INT_STAT 8'h04
`define LTS_OFS_INT_MASK 8'h08

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define LTS_ST_MAJOR_LSB 0
`define LTS_ST_SUB_LSB 4
`define LTS_ST_WIDTH_LSB 8
`define LTS_ST_COMPL_BIT 12

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define LTS_IRQ_STATE 0
`define LTS_IRQ_COMPL 1
`define LTS_IRQ_WIDTH 2
`define LTS_IRQ_BADSUB 3
`define LTS_IRQ_BITS 4

// ----------------------------------------
// Width codes, sub-state codes and reset values
// ----------------------------------------
`define LTS_WIDTH_NONE 3'h0
`define LTS_WIDTH_X1 3'h1
`define LTS_WIDTH_X4 3'h4
`define LTS_SUB_WAIT 3'h0
`define LTS_SUB_POL_COMPL 3'h2
`define LTS_INT_MASK_RST 4'h0

`endif

/* File: rtl/lts_pkg.sv */
// Types shared by the link training status report block
package lts_pkg;

	typedef enum logic [3:0] {
		LTS_DETECT = 4'h0,
		LTS_POLLING = 4'h1,
		LTS_CONFIG = 4'h2,
		LTS_L0 = 4'h3,
		LTS_L0S = 4'h4,
		LTS_L1 = 4'h5,
		LTS_L2 = 4'h6,
		LTS_RECOVERY = 4'h7,
		LTS_LOOPBACK = 4'h8,
		LTS_HOT_RESET = 4'h9,
		LTS_DISABLED = 4'ha
	} lts_major_t;

	typedef struct packed {
		lts_major_t major;
		logic [2:0] sub;
		logic [2:0] width;
		logic compliance;
	} lts_status_t;

	typedef struct packed {
		logic hsel;
		logic [7:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} lts_ahb_req_t;

endpackage

/* File: rtl/lts_report.sv */
// Link training status report with AHB-Lite status and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`include "lts_params.svh"
module lts_report (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// From the training state machine
	input wire lts_pkg::lts_major_t trainMajor,
	input wire logic [2:0] trainSub,
	input wire logic linkUp,
	input wire logic linkFourLanes,
	// To the application
	output lts_pkg::lts_status_t status,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Interrupt
	output logic irq
);
	import lts_pkg::*;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Both flops clear at once; logic leaves reset two edges after release
	logic rstMeta;
	logic rstN;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic [3:0] subCount(input lts_major_t m);
		unique case (m)
			LTS_DETECT: subCount = 4'h8;
			LTS_CONFIG: subCount = 4'h8;
			LTS_L0: subCount = 4'h7;
			LTS_POLLING: subCount = 4'h5;
			LTS_L0S: subCount = 4'h5;
			LTS_L1: subCount = 4'h4;
			LTS_L2: subCount = 4'h2;
			// States without listed sub-states accept any code
			default: subCount = 4'h8;
		endcase
	endfunction

	// Four-lane flag means nothing until the link is up
	function automatic logic [2:0] widthCode(input logic up, input logic four);
		if (!up) begin
			widthCode = `LTS_WIDTH_NONE;
		end else if (four) begin
			widthCode = `LTS_WIDTH_X4;
		end else begin
			widthCode = `LTS_WIDTH_X1;
		end
	endfunction

	function automatic logic regHit(input logic en, input logic [7:0] addr, input logic [7:0] ofs);
		regHit = en && (addr == ofs);
	endfunction

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	// One cycle of latency from the training inputs
	lts_status_t next_status;

	always_comb begin
		next_status.major = trainMajor;
		next_status.sub = trainSub;
		next_status.width = widthCode(linkUp, linkFourLanes);
		next_status.compliance = (trainMajor == LTS_POLLING) && (trainSub == `LTS_SUB_POL_COMPL);
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			status.major <= LTS_DETECT;
			status.sub <= `LTS_SUB_WAIT;
			status.width <= `LTS_WIDTH_NONE;
			status.compliance <= 1'b0;
		end else begin
			status <= next_status;
		end
	end

	// ----------------------------------------
	// Events
	// ----------------------------------------
	// One-cycle pulses into the sticky status bits, except BADSUB, which stays high as long as the bad code is held
	logic [`LTS_IRQ_BITS-1:0] events;

	always_comb begin
		events = '0;
		events[`LTS_IRQ_STATE] = (next_status.major != status.major) || (next_status.sub != status.sub);
		events[`LTS_IRQ_COMPL] = next_status.compliance && !status.compliance;
		events[`LTS_IRQ_WIDTH] = next_status.width != status.width;
		// Codes past the last sub-state of a major state are flagged, not altered
		events[`LTS_IRQ_BADSUB] = {1'b0, trainSub} >= subCount(trainMajor);
	end

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	// Size is ignored: only whole-word access is supported
	lts_ahb_req_t busReq;
	logic wrEn;
	logic [7:0] wrAddr;
	logic [31:0] wrData;
	logic rdEn;
	logic [7:0] rdAddr;

	assign busReq = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
		hsize: hsize, hwdata: hwdata, hready: hready};

	lts_ahb_slave u_slave (
		.clk(sys_clk),
		.rstN(rstN),
		.req(busReq),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.rdEn(rdEn),
		.rdAddr(rdAddr)
	);

	// No wait states and never an error response
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------
	// Interrupt registers
	// ----------------------------------------
	logic [`LTS_IRQ_BITS-1:0] intStat;
	logic [`LTS_IRQ_BITS-1:0] intMask;
	logic [`LTS_IRQ_BITS-1:0] w1c;
	logic [`LTS_IRQ_BITS-1:0] next_intStat;
	logic [`LTS_IRQ_BITS-1:0] next_intMask;
	logic statWrite;
	logic maskWrite;

	assign statWrite = regHit(wrEn, wrAddr, `LTS_OFS_INT_STAT);
	assign maskWrite = regHit(wrEn, wrAddr, `LTS_OFS_INT_MASK);
	assign w1c = statWrite ? wrData[`LTS_IRQ_BITS-1:0] : '0;
	assign next_intMask = maskWrite ? wrData[`LTS_IRQ_BITS-1:0] : intMask;

	// Set beats clear so an event in the clearing cycle survives
	for (genvar b = 0; b < `LTS_IRQ_BITS; b++) begin : g_stat
		assign next_intStat[b] = (intStat[b] && !w1c[b]) || events[b];
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			intStat <= '0;
		end else begin
			intStat <= next_intStat;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			intMask <= `LTS_INT_MASK_RST;
		end else begin
			intMask <= next_intMask;
		end
	end

	// Built from next values so a mask write shows on irq with no extra lag
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_intStat & next_intMask);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Launched at the end of the address phase, held until the next read
	logic [31:0] next_hrdata;

	always_comb begin
		next_hrdata = 32'h0000_0000;
		unique case (rdAddr)
			`LTS_OFS_STATUS: begin
				next_hrdata[`LTS_ST_MAJOR_LSB +: 4] = status.major;
				next_hrdata[`LTS_ST_SUB_LSB +: 3] = status.sub;
				next_hrdata[`LTS_ST_WIDTH_LSB +: 3] = status.width;
				next_hrdata[`LTS_ST_COMPL_BIT] = status.compliance;
			end
			`LTS_OFS_INT_STAT: next_hrdata[`LTS_IRQ_BITS-1:0] = intStat;
			`LTS_OFS_INT_MASK: next_hrdata[`LTS_IRQ_BITS-1:0] = intMask;
			// Unmapped addresses read zero with an OKAY response
			default: next_hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			hrdata <= 32'h0000_0000;
		end else if (rdEn) begin
			hrdata <= next_hrdata;
		end
	end
endmodule
`default_nettype wire

/* File: verif/lts_app_model.sv */
// Application-side model that decodes the reported status
`timescale 1ns/1ps
`default_nettype none
module lts_app_model (
	// Status from the block
	input wire lts_pkg::lts_status_t status,
	// Decoded view
	output logic polComp
);
	import lts_pkg::*;
	// Sub code means nothing without its major code
	assign polComp = status.major == LTS_POLLING && status.sub == 3'h2;
endmodule
`default_nettype wire

/* File: verif/lts_checker.sv */
// Assertions on the status outputs of the report block
`timescale 1ns/1ps
`default_nettype none
module lts_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Watched ports
	input wire lts_pkg::lts_major_t trainMajor,
	input wire logic [2:0] trainSub,
	input wire logic linkUp,
	input wire logic linkFourLanes,
	input wire lts_pkg::lts_status_t status
);
	import lts_pkg::*;
	logic [1:0] up;
	// Outputs may only move once the two release flops have passed
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence live_s; up == 2'h3; endsequence
	sequence pol_comp_s; trainMajor == LTS_POLLING && trainSub == 3'h2; endsequence
	major_follow_a: assert property (live_s |-> status.major == $past(trainMajor))
		else $error("major code wrong");
	sub_follow_a: assert property (live_s |-> status.sub == $past(trainSub))
		else $error("sub code wrong");
	width_code_a: assert property (live_s |-> status.width == (!$past(linkUp) ? 3'h0 : $past(linkFourLanes) ? 3'h4 : 3'h1))
		else $error("width code wrong");
	compl_on_a: assert property (live_s ##0 pol_comp_s |=> status.compliance)
		else $error("compliance flag missing");
	compl_only_a: assert property (live_s ##1 status.compliance |-> $past(trainMajor) == LTS_POLLING && $past(trainSub) == 3'h2)
		else $error("compliance flag stray");
	reset_view_a: assert property (up != 2'h3 |-> status == 11'h000)
		else $error("reset status wrong");
endmodule
bind lts_report lts_checker u_chk(.sys_clk(sys_clk), .arst_n(arst_n), .trainMajor(trainMajor), .trainSub(trainSub),
	.linkUp(linkUp), .linkFourLanes(linkFourLanes), .status(status));
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the link training status report block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lts_pkg::*;
	logic sys_clk, arst_n, linkUp, linkFourLanes, hsel, hwrite, hreadyout, hresp, irq, polComp;
	lts_major_t trainMajor;
	logic [2:0] trainSub, hsize;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	lts_status_t status;
	int mismatches, tests_run;
	lts_report dut(.sys_clk(sys_clk), .arst_n(arst_n), .trainMajor(trainMajor), .trainSub(trainSub), .linkUp(linkUp),
		.linkFourLanes(linkFourLanes), .status(status), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
	lts_app_model app(.status(status), .polComp(polComp));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, 1'b0);
		#1;
	endtask
	task setst(input lts_major_t m, input logic [2:0] s, input logic u, input logic f);
		@(posedge sys_clk);
		trainMajor <= m;
		trainSub <= s;
		linkUp <= u;
		linkFourLanes <= f;
		@(posedge sys_clk);
		#1;
	endtask
	// Inputs sit away from Detect during reset so a stuck output shows
	task t_reset;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(status, 0);
		@(posedge sys_clk);
		#1;
		chk(status.major, LTS_L0);
		$display("t_reset done");
	endtask
	task t_major;
		for (int i = 0; i < 11; i++) begin
			setst(lts_major_t'(i[3:0]), 3'h0, i[0], i[1]);
			chk(status.major, i);
			chk(status.width, i[0] ? (i[1] ? 3'h4 : 3'h1) : 3'h0);
			ahb(1'b0, 8'h00, 0);
			chk(rd[12:0], {2'h0, (i[0] ? (i[1] ? 3'h4 : 3'h1) : 3'h0), 4'h0, i[3:0]});
		end
		$display("t_major done");
	endtask
	task t_subs;
		for (int m = 0; m < 11; m++) begin
			for (int s = 0; s < 8; s++) begin
				setst(lts_major_t'(m[3:0]), s[2:0], 1'b1, 1'b1);
				chk(status.sub, s);
				chk(status.compliance, m == 1 && s == 2);
				chk(polComp, m == 1 && s == 2);
			end
		end
		$display("t_subs done");
	endtask
	task t_irq;
		ahb(1'b1, 8'h08, 0);
		setst(LTS_DETECT, 3'h0, 1'b0, 1'b0);
		ahb(1'b1, 8'h04, 32'hf);
		chk(irq, 0);
		setst(LTS_POLLING, 3'h2, 1'b0, 1'b0);
		ahb(1'b0, 8'h04, 0);
		chk(rd[3:0], 4'h3);
		chk(irq, 0);
		ahb(1'b0, 8'h00, 0);
		chk(rd, 32'h0000_1021);
		ahb(1'b1, 8'h08, 32'h2);
		chk(irq, 1);
		ahb(1'b1, 8'h04, 32'h2);
		chk(irq, 0);
		setst(LTS_L2, 3'h2, 1'b1, 1'b1);
		ahb(1'b0, 8'h04, 0);
		chk(rd[3:0], 4'hd);
		ahb(1'b1, 8'h08, 32'hf);
		chk(irq, 1);
		ahb(1'b0, 8'hfc, 0);
		chk(rd, 0);
		$display("t_irq done");
	endtask
	// Mid-run reset: outputs and mask must fall back while inputs stay away from Detect
	task t_rerun;
		@(posedge sys_clk);
		arst_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(status, 0);
		chk(irq, 0);
		@(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(status, 0);
		@(posedge sys_clk);
		#1;
		chk(status, {LTS_L2, 3'h2, 3'h4, 1'b0});
		ahb(1'b0, 8'h08, 0);
		chk(rd, 0);
		$display("t_rerun done");
	endtask
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		trainMajor = LTS_L0;
		trainSub = 3'h3;
		linkUp = 1'b1;
		linkFourLanes = 1'b0;
		mismatches = 0;
		tests_run = 0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset;
		t_major;
		t_subs;
		t_irq;
		t_rerun;
		test_done;
	end
	initial begin
		#50000;
		mismatches++;
		test_done;
	end
endmodule
`default_nettype wire
